// *** hwrs_device.sv ***
// sequencer device end: write fifo, waveform ram and playback engine
`timescale 1ns/100ps
`include "hwrs_defs.svh"

module hwrs_fifo #(
  parameter int WIDTH = `HWRS_FIFO_WIDTH,
  parameter int DEPTH = `HWRS_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } hwrs_fifo_st_t;
  hwrs_fifo_st_t r_q, r_d;
  logic push, pop;

  assign in_ready  = (r_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r_q.cnt != '0);
  assign out_data  = r_q.mem[r_q.rp];

  always_comb begin
    r_d  = r_q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      r_d.mem[r_q.wp] = in_data;
      r_d.wp = (r_q.wp == AW'(DEPTH-1)) ? '0 : r_q.wp + AW'(1);
    end
    if (pop) begin
      r_d.rp = (r_q.rp == AW'(DEPTH-1)) ? '0 : r_q.rp + AW'(1);
    end
    r_d.cnt = r_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule : hwrs_fifo

module hwrs_device #(
  parameter int TICK_SLOW_CYC  = `HWRS_TICK_SLOW_CYC,
  parameter int TICK_FAST_CYC  = `HWRS_TICK_FAST_CYC,
  parameter int PAUSE_UNIT_CYC = `HWRS_PAUSE_UNIT_CYC,
  parameter int BRAKE_CYC      = `HWRS_BRAKE_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  hwrs_if.dev       hif,
  output logic [7:0] drive_amplitude,
  output logic       braking,
  output logic       playing
);
  import hwrs_pkg::*;

  hwrs_dev_st_t r_q, r_d;
  logic [7:0]  ram [`HWRS_RAM_BYTES];
  hwrs_entry_t f_in, f_out;
  logic        f_valid, f_ready, drain;
  logic        req;
  logic [7:0]  slot, cfgb;
  logic [9:0]  base;
  logic [4:0]  size;

  function automatic logic signed [8:0] hwrs_amp(input logic [7:0] v, input logic sgn);
    hwrs_amp = sgn ? {{3{v[6]}}, v[5:0]} : {2'b00, v[6:0]};
  endfunction : hwrs_amp

  function automatic logic [7:0] hwrs_lerp(input logic signed [8:0] a, input logic signed [8:0] b,
                                           input logic [7:0] k, input logic [7:0] t);
    logic signed [9:0]  d;
    logic signed [18:0] p;
    logic signed [18:0] q;
    d = 10'(b) - 10'(a);
    p = 19'(d * $signed({1'b0, k}));
    q = (t == 8'h00) ? 19'sd0 : p / $signed({11'h000, t});
    hwrs_lerp = 8'(a + 9'(q));
  endfunction : hwrs_lerp

  assign f_in = '{sel: hif.wr_sel, addr: hif.wr_addr, data: hif.wr_data};
  // engine reads ram combinationally in these states, so writes wait
  assign f_ready = !(r_q.st == HWRS_ST_SLOT || r_q.st == HWRS_ST_ENTRY);
  assign drain   = f_valid && f_ready;

  hwrs_fifo #(.WIDTH(`HWRS_FIFO_WIDTH), .DEPTH(`HWRS_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (hif.wr_valid),
    .in_ready  (hif.wr_ready),
    .in_data   (f_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_out)
  );

  always_comb begin
    r_d = r_q;
    r_d.rd_valid = 1'b0;
    r_d.s1 = hif.trigger_or_irq_pin;
    r_d.s2 = r_q.s1;
    r_d.tprev = r_q.s2;
    req  = (r_q.tfunc == `HWRS_TFUNC_LEVEL) ? r_q.s2 : r_q.start;
    slot = r_q.slots[r_q.idx[2:0]];
    base = 10'(3 * slot[6:0]) - 10'd2;
    cfgb = ram[base + 10'd2];
    size = cfgb[4:0];
    case (r_q.st)
      HWRS_ST_IDLE: begin
        r_d.amp = 8'h00;
        r_d.brake = 1'b0;
        r_d.active = 1'b0;
        if (req) begin
          r_d.active = 1'b1;
          r_d.prog_err = 1'b0;
          r_d.idx = 4'h0;
          r_d.main_cnt = 3'h0;
          r_d.sloop_cnt = 2'h0;
          r_d.st = (r_q.mode == `HWRS_MODE_RTP) ? HWRS_ST_RTP : HWRS_ST_SLOT;
        end
      end
      HWRS_ST_RTP: begin
        r_d.amp = 8'(hwrs_amp(r_q.realtime_amplitude_playback, r_q.sfmt));
      end
      HWRS_ST_SLOT: begin
        r_d.amp = 8'h00;
        if (r_q.idx == `HWRS_SLOT_COUNT || slot == 8'h00) begin
          if (r_q.main_loop == `HWRS_MAIN_ENDLESS || r_q.main_cnt < r_q.main_loop) begin
            r_d.main_cnt = r_q.main_cnt + 3'h1;
            r_d.idx = 4'h0;
          end else begin
            r_d.start = 1'b0;
            r_d.cyc = 20'h0;
            r_d.st = r_q.brk_en ? HWRS_ST_BRAKE : HWRS_ST_IDLE;
          end
        end else if (slot[7]) begin
          r_d.pause = 1'b1;
          r_d.units = slot[6:0];
          r_d.cyc = 20'h0;
          r_d.st = HWRS_ST_PLAY;
        end else if (size == 5'h00 || size[0] || size > `HWRS_SIZE_MAX) begin
          r_d.prog_err = 1'b1;
          r_d.idx = r_q.idx + 4'h1;
        end else begin
          r_d.pause = 1'b0;
          r_d.wstart = {ram[base][1:0], ram[base + 10'd1]};
          r_d.wend = {ram[base][1:0], ram[base + 10'd1]} + 10'(size);
          r_d.ptr = {ram[base][1:0], ram[base + 10'd1]};
          r_d.reps = cfgb[7:5];
          r_d.rep = 3'h0;
          r_d.st = HWRS_ST_ENTRY;
        end
      end
      HWRS_ST_ENTRY: begin
        r_d.v1 = ram[r_q.ptr];
        r_d.tlen = ram[r_q.ptr + 10'd1];
        r_d.v2 = (r_q.ptr + 10'd2 < r_q.wend) ? ram[r_q.ptr + 10'd2] : ram[r_q.ptr];
        r_d.k = 8'h00;
        r_d.cyc = 20'h0;
        r_d.amp = 8'(hwrs_amp(ram[r_q.ptr], r_q.sfmt));
        r_d.st = HWRS_ST_PLAY;
      end
      HWRS_ST_PLAY: begin
        if (r_q.pause) begin
          r_d.amp = 8'h00;
          if (r_q.units == 7'h00) begin
            r_d.idx = r_q.idx + 4'h1;
            r_d.st = HWRS_ST_SLOT;
          end else if (r_q.cyc == 20'(PAUSE_UNIT_CYC - 1)) begin
            r_d.cyc = 20'h0;
            r_d.units = r_q.units - 7'h01;
          end else begin
            r_d.cyc = r_q.cyc + 20'h1;
          end
        end else if (r_q.k == r_q.tlen) begin
          r_d.ptr = r_q.ptr + 10'd2;
          r_d.st = HWRS_ST_ENTRY;
          if (r_q.ptr + 10'd2 >= r_q.wend) begin
            if (r_q.reps == `HWRS_REP_ENDLESS || r_q.rep < r_q.reps) begin
              r_d.rep = r_q.rep + 3'h1;
              r_d.ptr = r_q.wstart;
            end else if (r_q.sloop_cnt < r_q.sloops[r_q.idx[2:0]]) begin
              r_d.sloop_cnt = r_q.sloop_cnt + 2'h1;
              r_d.rep = 3'h0;
              r_d.ptr = r_q.wstart;
            end else begin
              r_d.sloop_cnt = 2'h0;
              r_d.idx = r_q.idx + 4'h1;
              r_d.st = HWRS_ST_SLOT;
            end
          end
        end else begin
          r_d.amp = r_q.v1[7] ? hwrs_lerp(hwrs_amp(r_q.v1, r_q.sfmt), hwrs_amp(r_q.v2, r_q.sfmt), r_q.k, r_q.tlen)
                              : 8'(hwrs_amp(r_q.v1, r_q.sfmt));
          if (r_q.cyc == 20'((r_q.tick_sel ? TICK_FAST_CYC : TICK_SLOW_CYC) - 1)) begin
            r_d.cyc = 20'h0;
            r_d.k = r_q.k + 8'h01;
          end else begin
            r_d.cyc = r_q.cyc + 20'h1;
          end
        end
      end
      HWRS_ST_BRAKE: begin
        r_d.amp = 8'h00;
        r_d.brake = 1'b1;
        if (r_q.cyc == 20'(BRAKE_CYC - 1)) begin
          r_d.brake = 1'b0;
          r_d.active = 1'b0;
          r_d.st = HWRS_ST_IDLE;
        end else begin
          r_d.cyc = r_q.cyc + 20'h1;
        end
      end
      default: r_d.st = HWRS_ST_IDLE;
    endcase
    // a stop request ends realtime or sequencer playback at once
    if (!req && r_q.st != HWRS_ST_IDLE && r_q.st != HWRS_ST_BRAKE) begin
      r_d.amp = 8'h00;
      r_d.cyc = 20'h0;
      r_d.st = r_q.brk_en ? HWRS_ST_BRAKE : HWRS_ST_IDLE;
    end
    // software writes come after the engine so a new start beats the self-clear
    if (drain && f_out.sel) begin
      case (f_out.addr[7:0])
        `HWRS_CFG_CTRL: begin
          r_d.start = f_out.data[`HWRS_CTRL_START];
          r_d.mode = f_out.data[`HWRS_CTRL_MODE];
          r_d.tfunc = f_out.data[`HWRS_CTRL_TFUNC +: 2];
          r_d.brk_en = f_out.data[`HWRS_CTRL_BRAKE];
          r_d.tick_sel = f_out.data[`HWRS_CTRL_TICK];
          r_d.sfmt = f_out.data[`HWRS_CTRL_SIGNED];
        end
        `HWRS_CFG_LOOP_LO:   r_d.sloops[3:0] = f_out.data;
        `HWRS_CFG_LOOP_HI:   r_d.sloops[7:4] = f_out.data;
        `HWRS_CFG_MAIN_LOOP: r_d.main_loop = f_out.data[2:0];
        `HWRS_CFG_RTP:       r_d.realtime_amplitude_playback = f_out.data;
        default: begin
          if (f_out.addr[7:0] >= `HWRS_CFG_SLOT_FIRST && f_out.addr[7:0] <= `HWRS_CFG_SLOT_LAST) begin
            r_d.slots[3'(f_out.addr[7:0] - `HWRS_CFG_SLOT_FIRST)] = f_out.data;
          end
        end
      endcase
    end
    // pulse mode: each rising edge toggles between start and stop
    if (r_q.tfunc == `HWRS_TFUNC_PULSE && r_q.s2 && !r_q.tprev) begin
      r_d.start = !r_q.active;
    end
    // reads wait for queued writes so they see the latest data
    if (hif.rd_en && !f_valid && !r_q.rd_valid) begin
      r_d.rd_valid = 1'b1;
      if (!hif.wr_sel) begin
        r_d.rd_data = ram[hif.wr_addr];
      end else begin
        case (hif.wr_addr[7:0])
          `HWRS_CFG_CTRL:      r_d.rd_data = {1'b0, r_q.sfmt, r_q.tick_sel, r_q.brk_en, r_q.tfunc, r_q.mode, r_q.start};
          `HWRS_CFG_LOOP_LO:   r_d.rd_data = r_q.sloops[3:0];
          `HWRS_CFG_LOOP_HI:   r_d.rd_data = r_q.sloops[7:4];
          `HWRS_CFG_MAIN_LOOP: r_d.rd_data = {5'h00, r_q.main_loop};
          `HWRS_CFG_RTP:       r_d.rd_data = r_q.realtime_amplitude_playback;
          `HWRS_CFG_STATUS:    r_d.rd_data = {r_q.active, r_q.brake, r_q.prog_err, 1'b0, r_q.idx};
          default: begin
            r_d.rd_data = 8'h00;
            if (hif.wr_addr[7:0] >= `HWRS_CFG_SLOT_FIRST && hif.wr_addr[7:0] <= `HWRS_CFG_SLOT_LAST) begin
              r_d.rd_data = r_q.slots[3'(hif.wr_addr[7:0] - `HWRS_CFG_SLOT_FIRST)];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (drain && !f_out.sel) begin
      ram[f_out.addr] <= f_out.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.st <= HWRS_ST_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  assign hif.rd_valid    = r_q.rd_valid;
  assign hif.rd_data     = r_q.rd_data;
  assign drive_amplitude = r_q.amp;
  assign braking         = r_q.brake;
  assign playing         = r_q.active;
endmodule : hwrs_device

// *** hwrs_defs.svh ***
// constants for the haptic waveform ram sequencer
// Notes on behaviour
// - one kilobyte waveform ram on chip
// - host writes revision byte zero, header, data
// - header entry: two address bytes, one config byte
// - host stores at most 127 effects
// - effect id is header position, first is one
// - effect size even, 2 to 30, else error
// - repeat field: 0 once, 7 endless
// - low seven voltage bits amplitude, msb ramp
// - hold time: 5 ms or 1 ms ticks
// - ramp interpolates to next amplitude over time
// - slots play from first, stop at zero/eight
// - slot msb set: pause in 10 ms units
// - slot loops, then whole sequence loops
// - start bit or trigger pin starts playback
// - start bit plays or stops; level ignores it
// - realtime runs until stopped; sequencer ends itself
// - brake phase before standby when enabled
`ifndef HWRS_DEFS_SVH
`define HWRS_DEFS_SVH

`define HWRS_RAM_BYTES      1024
`define HWRS_MAX_EFFECTS    127
`define HWRS_SIZE_MAX       5'h1E
`define HWRS_REP_ENDLESS    3'h7
`define HWRS_MAIN_ENDLESS   3'h7
`define HWRS_SLOT_COUNT     4'h8
`define HWRS_FIFO_DEPTH     4
`define HWRS_FIFO_WIDTH     19

`define HWRS_CLK_MHZ        100
`define HWRS_TICK_SLOW_US   5000
`define HWRS_TICK_FAST_US   1000
`define HWRS_PAUSE_UNIT_US  10000
`define HWRS_BRAKE_US       10000
`define HWRS_TICK_SLOW_CYC  (`HWRS_TICK_SLOW_US * `HWRS_CLK_MHZ)
`define HWRS_TICK_FAST_CYC  (`HWRS_TICK_FAST_US * `HWRS_CLK_MHZ)
`define HWRS_PAUSE_UNIT_CYC (`HWRS_PAUSE_UNIT_US * `HWRS_CLK_MHZ)
`define HWRS_BRAKE_CYC      (`HWRS_BRAKE_US * `HWRS_CLK_MHZ)

`define HWRS_CFG_CTRL       8'h00
`define HWRS_CFG_SLOT_FIRST 8'h01
`define HWRS_CFG_SLOT_LAST  8'h08
`define HWRS_CFG_LOOP_LO    8'h09
`define HWRS_CFG_LOOP_HI    8'h0A
`define HWRS_CFG_MAIN_LOOP  8'h0B
`define HWRS_CFG_RTP        8'h0C
`define HWRS_CFG_STATUS     8'h0D

`define HWRS_CTRL_START     0
`define HWRS_CTRL_MODE      1
`define HWRS_CTRL_TFUNC     2
`define HWRS_CTRL_BRAKE     4
`define HWRS_CTRL_TICK      5
`define HWRS_CTRL_SIGNED    6

`define HWRS_TFUNC_PULSE    2'h0
`define HWRS_TFUNC_LEVEL    2'h1
`define HWRS_MODE_RTP       1'h0

`endif

// *** hwrs_pkg.sv ***
// types shared by both ends of the haptic sequencer link
package hwrs_pkg;

  typedef enum logic [5:0] {
    HWRS_ST_IDLE  = 6'h01,
    HWRS_ST_RTP   = 6'h02,
    HWRS_ST_SLOT  = 6'h04,
    HWRS_ST_ENTRY = 6'h08,
    HWRS_ST_PLAY  = 6'h10,
    HWRS_ST_BRAKE = 6'h20
  } hwrs_state_t;

  typedef enum logic [2:0] {
    HWRS_HS_IDLE = 3'h1,
    HWRS_HS_WR   = 3'h2,
    HWRS_HS_RD   = 3'h4
  } hwrs_host_state_t;

  typedef struct packed {
    logic       sel;
    logic [9:0] addr;
    logic [7:0] data;
  } hwrs_entry_t;

  typedef struct packed {
    hwrs_state_t     st;
    logic            start;
    logic            mode;
    logic [1:0]      tfunc;
    logic            brk_en;
    logic            tick_sel;
    logic            sfmt;
    logic [7:0][7:0] slots;
    logic [7:0][1:0] sloops;
    logic [2:0]      main_loop;
    logic [7:0]      realtime_amplitude_playback;
    logic [3:0]      idx;
    logic [2:0]      main_cnt;
    logic [1:0]      sloop_cnt;
    logic [2:0]      rep;
    logic [2:0]      reps;
    logic [9:0]      wstart;
    logic [9:0]      wend;
    logic [9:0]      ptr;
    logic [7:0]      v1;
    logic [7:0]      v2;
    logic [7:0]      tlen;
    logic [7:0]      k;
    logic [19:0]     cyc;
    logic [6:0]      units;
    logic            pause;
    logic            s1;
    logic            s2;
    logic            tprev;
    logic [7:0]      amp;
    logic            brake;
    logic            active;
    logic            prog_err;
    logic            rd_valid;
    logic [7:0]      rd_data;
  } hwrs_dev_st_t;

  typedef struct packed {
    hwrs_host_state_t st;
    logic             cmd_ready;
    logic             rsp_valid;
    logic [7:0]       rsp_data;
    logic             wr_valid;
    logic             rd_en;
    logic             sel;
    logic [9:0]       addr;
    logic [7:0]       data;
    logic             trig;
  } hwrs_host_st_t;

endpackage : hwrs_pkg

// *** hwrs_if.sv ***
// link between the host controller and the sequencer device
`timescale 1ns/100ps
interface hwrs_if;
  logic       wr_valid;
  logic       wr_ready;
  logic       wr_sel;
  logic [9:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_en;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       trigger_or_irq_pin;

  modport dev (
    input  wr_valid,
    output wr_ready,
    input  wr_sel,
    input  wr_addr,
    input  wr_data,
    input  rd_en,
    output rd_valid,
    output rd_data,
    input  trigger_or_irq_pin
  );

  modport host (
    output wr_valid,
    input  wr_ready,
    output wr_sel,
    output wr_addr,
    output wr_data,
    output rd_en,
    input  rd_valid,
    input  rd_data,
    output trigger_or_irq_pin
  );
endinterface : hwrs_if

// *** hwrs_host.sv ***
// host end: turns user commands into link writes and reads
`timescale 1ns/100ps
`include "hwrs_defs.svh"

module hwrs_host (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  hwrs_if.host            hif,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic       cmd_sel,
  input  wire logic [9:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  input  wire logic       trig_level
);
  import hwrs_pkg::*;

  hwrs_host_st_t r_q, r_d;

  always_comb begin
    r_d = r_q;
    r_d.rsp_valid = 1'b0;
    r_d.trig = trig_level;
    case (r_q.st)
      HWRS_HS_IDLE: begin
        if (cmd_valid) begin
          r_d.cmd_ready = 1'b0;
          r_d.sel = cmd_sel;
          r_d.addr = cmd_addr;
          r_d.data = cmd_wdata;
          r_d.wr_valid = cmd_write;
          r_d.rd_en = !cmd_write;
          r_d.st = cmd_write ? HWRS_HS_WR : HWRS_HS_RD;
        end
      end
      HWRS_HS_WR: begin
        if (hif.wr_ready) begin
          r_d.wr_valid = 1'b0;
          r_d.cmd_ready = 1'b1;
          r_d.st = HWRS_HS_IDLE;
        end
      end
      HWRS_HS_RD: begin
        if (hif.rd_valid) begin
          r_d.rd_en = 1'b0;
          r_d.rsp_valid = 1'b1;
          r_d.rsp_data = hif.rd_data;
          r_d.cmd_ready = 1'b1;
          r_d.st = HWRS_HS_IDLE;
        end
      end
      default: r_d.st = HWRS_HS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.st <= HWRS_HS_IDLE;
      r_q.cmd_ready <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign hif.wr_valid           = r_q.wr_valid;
  assign hif.wr_sel             = r_q.sel;
  assign hif.wr_addr            = r_q.addr;
  assign hif.wr_data            = r_q.data;
  assign hif.rd_en              = r_q.rd_en;
  assign hif.trigger_or_irq_pin = r_q.trig;
  assign cmd_ready              = r_q.cmd_ready;
  assign rsp_valid              = r_q.rsp_valid;
  assign rsp_data               = r_q.rsp_data;
endmodule : hwrs_host

// *** hwrs_properties.sv ***
// concurrent checks on the host-device link and the device outputs
`timescale 1ns/100ps
module hwrs_properties (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic       wr_sel,
  input wire logic [9:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       rd_en,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic       trigger_or_irq_pin,
  input wire logic [7:0] drive_amplitude,
  input wire logic       braking,
  input wire logic       playing
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_wr_req_held: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_sel, wr_addr, wr_data}))
    else $error("write request changed before acceptance");
  a_rd_req_held: assert property (rd_en && !rd_valid |=> rd_en)
    else $error("read request dropped before answer");
  a_rd_one_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_rd_data_stands: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data changed without read valid");
  a_rd_answers_req: assert property (rd_valid |-> $past(rd_en))
    else $error("read valid without read request");
  a_brake_quiet: assert property (braking |-> drive_amplitude == 8'h00)
    else $error("amplitude not zero while braking");
  // fixed brake length of 15 cycles, small slack on the release
  a_brake_span: assert property ($rose(braking) |-> braking[*8] ##1 braking[*7] ##[1:3] !braking)
    else $error("brake phase length wrong");
  a_brake_in_play: assert property (braking |-> playing)
    else $error("braking outside playback");
  a_idle_quiet: assert property (!playing && !$past(playing) |-> drive_amplitude == 8'h00)
    else $error("amplitude driven in standby");
endmodule : hwrs_properties

// *** haptic_waveform_ram_sequencer_test.sv ***
// self-checking bench joining host and device ends
`timescale 1ns/100ps
module haptic_waveform_ram_sequencer_test;
  logic       mclk;
  logic       sys_rst;
  logic       cmd_valid;
  logic       cmd_write;
  logic       cmd_sel;
  logic [9:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       trig_level;
  logic [7:0] drive_amplitude;
  logic       braking;
  logic       playing;
  logic [7:0] hold_amp;
  logic       saw_mid;
  logic       saw_neg;
  int         hold_cnt;
  int         zero_cnt;
  int         fails;
  int         num_checks;
  int         cycles;
  // library: revision, four headers (last has odd size), data
  localparam logic [17:0] LIB [21] = '{
    {10'h000, 8'h00}, {10'h001, 8'h01}, {10'h002, 8'h00}, {10'h003, 8'h22}, {10'h004, 8'h00},
    {10'h005, 8'h20}, {10'h006, 8'h04}, {10'h007, 8'h00}, {10'h008, 8'h30}, {10'h009, 8'h02},
    {10'h00A, 8'h00}, {10'h00B, 8'h40}, {10'h00C, 8'h03}, {10'h100, 8'h20}, {10'h101, 8'h02},
    {10'h020, 8'h90}, {10'h021, 8'h04}, {10'h022, 8'h30}, {10'h023, 8'h01}, {10'h030, 8'h41},
    {10'h031, 8'h01}};

  hwrs_if hwrs_if_inst ();
  hwrs_device #(.TICK_SLOW_CYC(50), .TICK_FAST_CYC(10), .PAUSE_UNIT_CYC(20), .BRAKE_CYC(16)) hwrs_device_inst (
    .mclk(mclk), .sys_rst(sys_rst), .hif(hwrs_if_inst), .drive_amplitude(drive_amplitude),
    .braking(braking), .playing(playing));
  hwrs_host hwrs_host_inst (
    .mclk(mclk), .sys_rst(sys_rst), .hif(hwrs_if_inst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .trig_level(trig_level));
  hwrs_properties hwrs_properties_inst (
    .mclk(mclk), .sys_rst(sys_rst), .wr_valid(hwrs_if_inst.wr_valid), .wr_ready(hwrs_if_inst.wr_ready),
    .wr_sel(hwrs_if_inst.wr_sel), .wr_addr(hwrs_if_inst.wr_addr), .wr_data(hwrs_if_inst.wr_data),
    .rd_en(hwrs_if_inst.rd_en), .rd_valid(hwrs_if_inst.rd_valid), .rd_data(hwrs_if_inst.rd_data),
    .trigger_or_irq_pin(hwrs_if_inst.trigger_or_irq_pin), .drive_amplitude(drive_amplitude),
    .braking(braking), .playing(playing));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (playing === 1'b1) begin
      if (drive_amplitude === hold_amp) hold_cnt++;
      if (drive_amplitude === 8'h00) zero_cnt++;
      if (drive_amplitude > 8'h10 && drive_amplitude < 8'h30) saw_mid = 1'b1;
      if (drive_amplitude === 8'hC1) saw_neg = 1'b1;
    end
  end

  // ceiling well above the several hundred cycles the scenarios need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  task automatic cmd(input logic w, input logic s, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
    int i;
    r = 8'h00;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge mclk);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_sel   <= s;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) r = rsp_data;
      if (cmd_ready === 1'b1) break;
    end
  endtask : cmd

  task automatic wr(input logic s, input logic [9:0] a, input logic [7:0] d);
    logic [7:0] r;
    cmd(1'b1, s, a, d, r);
  endtask : wr

  task automatic wait_out(input int which, input logic v);
    int i;
    for (i = 0; i < 3000 && (which == 0 ? playing : braking) !== v; i++) @(negedge mclk);
    chk(which == 0 ? "playing" : "braking", {7'h00, v}, {7'h00, which == 0 ? playing : braking});
  endtask : wait_out

  task automatic t_reset();
    chk("drive_amplitude", 8'h00, drive_amplitude);
    chk("playing", 8'h00, {7'h00, playing});
    chk("cmd_ready", 8'h01, {7'h00, cmd_ready});
  endtask : t_reset

  task automatic t_ram();
    logic [7:0] r;
    wr(1'b0, 10'h3FF, 8'hA5);
    wr(1'b0, 10'h200, 8'h5A);
    cmd(1'b0, 1'b0, 10'h3FF, 8'h00, r);
    chk("ram_top", 8'hA5, r);
    cmd(1'b0, 1'b0, 10'h200, 8'h00, r);
    chk("ram_mid", 8'h5A, r);
    cmd(1'b0, 1'b1, 10'h00F, 8'h00, r);
    chk("unmapped", 8'h00, r);
    // four header entries, well inside the effect limit
    foreach (LIB[i]) wr(1'b0, LIB[i][17:8], LIB[i][7:0]);
  endtask : t_ram

  task automatic t_seq();
    logic [7:0] r;
    wr(1'b1, 10'h001, 8'h01);
    wr(1'b1, 10'h002, 8'h81);
    wr(1'b1, 10'h003, 8'h04);
    wr(1'b1, 10'h004, 8'h00);
    wr(1'b1, 10'h009, 8'h01);
    wr(1'b1, 10'h00B, 8'h00);
    hold_amp = 8'h20;
    hold_cnt = 0;
    zero_cnt = 0;
    wr(1'b1, 10'h000, 8'h03);
    wait_out(0, 1'b1);
    wait_out(0, 1'b0);
    // two plays per slot loop, two ticks of 50 cycles each, fetch slack
    chk("effect_cycles", 8'h01, {7'h00, hold_cnt >= 400 && hold_cnt <= 408});
    chk("pause_zero", 8'h01, {7'h00, zero_cnt >= 20});
    cmd(1'b0, 1'b1, 10'h000, 8'h00, r);
    chk("control", 8'h02, r);
    cmd(1'b0, 1'b1, 10'h00D, 8'h00, r);
    chk("prog_err", 8'h20, r & 8'h20);
  endtask : t_seq

  task automatic t_ramp();
    logic [7:0] r;
    wr(1'b1, 10'h001, 8'h02);
    wr(1'b1, 10'h002, 8'h03);
    wr(1'b1, 10'h003, 8'h00);
    wr(1'b1, 10'h009, 8'h00);
    saw_mid = 1'b0;
    saw_neg = 1'b0;
    hold_amp = 8'h30;
    hold_cnt = 0;
    wr(1'b1, 10'h000, 8'h63);
    wait_out(0, 1'b1);
    wait_out(0, 1'b0);
    chk("ramp_mid", 8'h01, {7'h00, saw_mid});
    chk("ramp_end", 8'h01, {7'h00, hold_cnt >= 10 && hold_cnt <= 20});
    chk("signed_amp", 8'h01, {7'h00, saw_neg});
    cmd(1'b0, 1'b1, 10'h00D, 8'h00, r);
    chk("prog_err", 8'h00, r & 8'h20);
  endtask : t_ramp

  task automatic t_rtp();
    wr(1'b1, 10'h00C, 8'h25);
    wr(1'b1, 10'h000, 8'h11);
    wait_out(0, 1'b1);
    repeat (30) @(negedge mclk);
    chk("rtp_amp", 8'h25, drive_amplitude);
    chk("playing", 8'h01, {7'h00, playing});
    wr(1'b1, 10'h000, 8'h10);
    wait_out(1, 1'b1);
    wait_out(1, 1'b0);
    repeat (2) @(negedge mclk);
    chk("playing", 8'h00, {7'h00, playing});
  endtask : t_rtp

  task automatic t_level();
    wr(1'b1, 10'h000, 8'h05);
    repeat (10) @(negedge mclk);
    chk("playing", 8'h00, {7'h00, playing});
    @(posedge mclk);
    trig_level <= 1'b1;
    wait_out(0, 1'b1);
    @(posedge mclk);
    trig_level <= 1'b0;
    wait_out(0, 1'b0);
    wr(1'b1, 10'h000, 8'h00);
  endtask : t_level

  // pulse trigger: first rising edge starts, falling edge does nothing, next rising edge stops
  task automatic t_pulse();
    @(posedge mclk);
    trig_level <= 1'b1;
    wait_out(0, 1'b1);
    @(posedge mclk);
    trig_level <= 1'b0;
    repeat (5) @(negedge mclk);
    chk("playing", 8'h01, {7'h00, playing});
    chk("rtp_amp", 8'h25, drive_amplitude);
    @(posedge mclk);
    trig_level <= 1'b1;
    wait_out(0, 1'b0);
    @(posedge mclk);
    trig_level <= 1'b0;
  endtask : t_pulse

  initial begin
    sys_rst    = 1'b1;
    cmd_valid  = 1'b0;
    cmd_write  = 1'b0;
    cmd_sel    = 1'b0;
    cmd_addr   = 10'h000;
    cmd_wdata  = 8'h00;
    trig_level = 1'b0;
    hold_amp   = 8'h00;
    saw_mid    = 1'b0;
    saw_neg    = 1'b0;
    hold_cnt   = 0;
    zero_cnt   = 0;
    fails      = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    t_reset();
    t_ram();
    t_seq();
    t_ramp();
    t_rtp();
    t_level();
    t_pulse();
    summarize();
  end
endmodule : haptic_waveform_ram_sequencer_test
